// ### design/camb_pkg.sv
// Shared constants and types for the execution block
package camb_pkg;
   // ----------------------------------------------------------------
   // Instruction word fields
   // ----------------------------------------------------------------
   localparam int INSTR_W = 24;
   localparam int OPC_MSB = 23;
   localparam int RD_MSB = 18;
   localparam int RR_MSB = 13;
   localparam int IMM_MSB = 7;
   localparam int BIT_MSB = 2;
   localparam int OFS_MSB = 6;
   // ----------------------------------------------------------------
   // Operation codes
   // ----------------------------------------------------------------
   localparam logic [4:0] OP_NOP = 5'h00;
   localparam logic [4:0] OP_CLR_BITS = 5'h01;
   localparam logic [4:0] OP_REG_TEST = 5'h02;
   localparam logic [4:0] OP_MPY_U = 5'h03;
   localparam logic [4:0] OP_MPY_S = 5'h04;
   localparam logic [4:0] OP_MPY_SU = 5'h05;
   localparam logic [4:0] OP_FMPY_U = 5'h06;
   localparam logic [4:0] OP_FMPY_S = 5'h07;
   localparam logic [4:0] OP_FMPY_SU = 5'h08;
   localparam logic [4:0] OP_IND_JUMP = 5'h09;
   localparam logic [4:0] OP_IND_CALL = 5'h0a;
   localparam logic [4:0] OP_SKIP_EQ = 5'h0b;
   localparam logic [4:0] OP_SKIP_RCLR = 5'h0c;
   localparam logic [4:0] OP_SKIP_RSET = 5'h0d;
   localparam logic [4:0] OP_SKIP_IOCLR = 5'h0e;
   localparam logic [4:0] OP_SKIP_IOSET = 5'h0f;
   localparam logic [4:0] OP_CMP_REG = 5'h10;
   localparam logic [4:0] OP_CMP_CARRY = 5'h11;
   localparam logic [4:0] OP_CMP_IMM = 5'h12;
   localparam logic [4:0] OP_BR_FSET = 5'h13;
   localparam logic [4:0] OP_BR_FCLR = 5'h14;
   localparam logic [4:0] OP_BR_ZSET = 5'h15;
   localparam logic [4:0] OP_BR_ZCLR = 5'h16;
   localparam logic [4:0] OP_BR_CSET = 5'h17;
   localparam logic [4:0] OP_BR_CCLR = 5'h18;
   // ----------------------------------------------------------------
   // Status flag positions, fixed registers, reset values
   // ----------------------------------------------------------------
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_H = 5;
   localparam logic [7:0] CLR_MASK = 8'hff;
   localparam logic [4:0] ZPTR_LO = 5'h1e;
   localparam logic [4:0] ZPTR_HI = 5'h1f;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic RUN_RST = 1'b1;
   // ----------------------------------------------------------------
   // Bus register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam logic [7:0] REG_STATUS = 8'h80;
   localparam logic [7:0] REG_PC = 8'h84;
   localparam logic [7:0] REG_SP = 8'h88;
   localparam logic [7:0] REG_CTRL = 8'h8c;
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_MULT = 3'b010,
      ST_HOLD = 3'b100
   } camb_state_t;
endpackage

// ### design/camb_alu.sv
// Subtract and logic unit with status flag outputs
`timescale 1ns/1ps
module camb_alu (
   input wire logic [7:0] a_i, // First operand
   input wire logic [7:0] b_i, // Second operand
   input wire logic c_i, // Borrow in
   input wire logic z_i, // Previous zero flag
   input wire logic sub_i, // 1 subtract, 0 and
   input wire logic chain_i, // Zero flag chains previous value
   output logic [7:0] res_o, // Result
   output logic z_o, // Zero
   output logic n_o, // Negative
   output logic v_o, // Overflow
   output logic c_o, // Borrow out
   output logic h_o // Half borrow
);
   logic [8:0] diff;
   assign diff = {1'b0, a_i} - {1'b0, b_i} - {8'h00, c_i};
   assign res_o = sub_i ? diff[7:0] : (a_i & b_i);
   assign z_o = ~|res_o & (chain_i ? z_i : 1'b1);
   assign n_o = res_o[7];
   assign v_o = sub_i & ((a_i[7] & ~b_i[7] & ~res_o[7]) | (~a_i[7] & b_i[7] & res_o[7]));
   assign c_o = sub_i & ((~a_i[7] & b_i[7]) | (b_i[7] & res_o[7]) | (res_o[7] & ~a_i[7]));
   assign h_o = sub_i & ((~a_i[3] & b_i[3]) | (b_i[3] & res_o[3]) | (res_o[3] & ~a_i[3]));
endmodule // camb_alu

// ### design/camb_mult.sv
// Two-cycle multiplier: operands captured, product formed next cycle
`timescale 1ns/1ps
module camb_mult #(
   parameter int W = 8
) (
   input wire logic clk_i, // Clock
   input wire logic start_i, // Capture operands
   input wire logic sgn_a_i, // First operand signed
   input wire logic sgn_b_i, // Second operand signed
   input wire logic frac_i, // Fractional form
   input wire logic [W-1:0] a_i, // First operand
   input wire logic [W-1:0] b_i, // Second operand
   output logic [2*W-1:0] prod_o, // Product to write
   output logic z_o, // Written product is zero
   output logic c_o // Top bit of unshifted product
);
   logic [W:0] xa;
   logic [W:0] xb;
   logic frac;
   logic signed [2*W+1:0] full;
   logic [2*W-1:0] raw;
   always_ff @(posedge clk_i) begin
      if (start_i) begin
         xa <= {sgn_a_i & a_i[W-1], a_i};
         xb <= {sgn_b_i & b_i[W-1], b_i};
         frac <= frac_i;
      end
   end
   assign full = $signed(xa) * $signed(xb);
   assign raw = full[2*W-1:0];
   assign prod_o = frac ? {raw[2*W-2:0], 1'b0} : raw;
   assign c_o = raw[2*W-1];
   assign z_o = (prod_o == '0);
endmodule // camb_mult

// ### design/camb_core.sv
// Execution core for logic, multiply, indirect jump, compare, skip and branch
`timescale 1ns/1ps
module camb_core import camb_pkg::*; #(
   parameter int STACK_DEPTH = 16
) (
   input wire logic clk_i, // Clock, 250 MHz
   input wire logic rst_i, // Synchronous reset, high
   input wire logic cyc_i, // Wishbone cycle
   input wire logic stb_i, // Wishbone strobe
   input wire logic we_i, // Wishbone write
   input wire logic [ADR_W-1:0] adr_i, // Wishbone byte address
   input wire logic [31:0] dat_i, // Wishbone write data
   input wire logic [3:0] sel_i, // Wishbone byte lanes
   output logic [31:0] dat_o, // Wishbone read data
   output logic ack_o, // Wishbone acknowledge
   input wire logic instr_valid_i, // Instruction offered
   input wire logic [INSTR_W-1:0] instr_i, // Instruction word
   input wire logic next_long_i, // Following instruction is two words
   input wire logic [7:0] io_byte_i, // I/O register named by instruction
   output logic ready_o, // Instruction taken this edge if valid
   output logic [15:0] pc_o, // Program counter
   output logic [7:0] status_o // Status flags
);
   localparam int SPW = $clog2(STACK_DEPTH);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] gpr [0:31];
   logic [15:0] stack [0:STACK_DEPTH-1];
   logic [SPW-1:0] sp;
   logic run;
   camb_state_t state;
   camb_state_t next_state;
   logic [1:0] cnt;
   logic [1:0] next_cnt;
   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [4:0] opc;
   logic [4:0] rd;
   logic [4:0] rr;
   logic [7:0] kimm;
   logic [2:0] bsel;
   logic [6:0] ofs;
   logic [7:0] vd;
   logic [7:0] vr;
   logic acc;
   logic is_mult;
   logic is_logic;
   logic is_cmp;
   logic is_skip;
   logic is_br;
   assign opc = instr_i[OPC_MSB -: 5];
   assign rd = instr_i[RD_MSB -: 5];
   assign rr = instr_i[RR_MSB -: 5];
   assign kimm = instr_i[IMM_MSB -: 8];
   assign bsel = instr_i[BIT_MSB -: 3];
   assign ofs = instr_i[OFS_MSB -: 7];
   assign vd = gpr[rd];
   assign vr = gpr[rr];
   assign acc = instr_valid_i && ready_o;
   assign is_mult = (opc >= OP_MPY_U) && (opc <= OP_FMPY_SU);
   assign is_logic = (opc == OP_CLR_BITS) || (opc == OP_REG_TEST);
   assign is_cmp = (opc >= OP_CMP_REG) && (opc <= OP_CMP_IMM);
   assign is_skip = (opc >= OP_SKIP_EQ) && (opc <= OP_SKIP_IOSET);
   assign is_br = (opc >= OP_BR_FSET) && (opc <= OP_BR_CCLR);
   // ----------------------------------------------------------------
   // Compare and logic unit
   // ----------------------------------------------------------------
   logic [7:0] alu_b;
   logic [7:0] alu_res;
   logic alu_z;
   logic alu_n;
   logic alu_v;
   logic alu_c;
   logic alu_h;
   assign alu_b = (opc == OP_CLR_BITS) ? (CLR_MASK - kimm) :
                  (opc == OP_REG_TEST) ? vd :
                  (opc == OP_CMP_IMM) ? kimm : vr;
   camb_alu u_alu (
      .a_i(vd),
      .b_i(alu_b),
      .c_i((opc == OP_CMP_CARRY) & status_o[FLG_C]),
      .z_i(status_o[FLG_Z]),
      .sub_i(is_cmp),
      .chain_i(opc == OP_CMP_CARRY),
      .res_o(alu_res),
      .z_o(alu_z),
      .n_o(alu_n),
      .v_o(alu_v),
      .c_o(alu_c),
      .h_o(alu_h)
   );
   // ----------------------------------------------------------------
   // Multiplier
   // ----------------------------------------------------------------
   logic [15:0] mult_prod;
   logic mult_z;
   logic mult_c;
   camb_mult #(.W(8)) u_mult (
      .clk_i(clk_i),
      .start_i(acc && is_mult),
      .sgn_a_i((opc == OP_MPY_S) || (opc == OP_MPY_SU) || (opc == OP_FMPY_S) ||
               (opc == OP_FMPY_SU)),
      .sgn_b_i((opc == OP_MPY_S) || (opc == OP_FMPY_S)),
      .frac_i(opc >= OP_FMPY_U),
      .a_i(vd),
      .b_i(vr),
      .prod_o(mult_prod),
      .z_o(mult_z),
      .c_o(mult_c)
   );
   // ----------------------------------------------------------------
   // Skip, branch and next program counter
   // ----------------------------------------------------------------
   logic skip_now;
   logic [2:0] br_sel;
   logic br_want;
   logic br_taken;
   logic [15:0] zptr;
   logic [15:0] br_target;
   logic [15:0] skip_pc;
   logic [15:0] acc_pc;
   logic [1:0] extra;
   assign skip_now = (opc == OP_SKIP_EQ) ? (vd == vr) :
                     (opc == OP_SKIP_RCLR) ? ~vr[bsel] :
                     (opc == OP_SKIP_RSET) ? vr[bsel] :
                     (opc == OP_SKIP_IOCLR) ? ~io_byte_i[bsel] :
                     (opc == OP_SKIP_IOSET) ? io_byte_i[bsel] : 1'b0;
   assign br_sel = ((opc == OP_BR_FSET) || (opc == OP_BR_FCLR)) ? bsel :
                   ((opc == OP_BR_ZSET) || (opc == OP_BR_ZCLR)) ? 3'(FLG_Z) : 3'(FLG_C);
   assign br_want = (opc == OP_BR_FSET) || (opc == OP_BR_ZSET) || (opc == OP_BR_CSET);
   assign br_taken = is_br && (status_o[br_sel] == br_want);
   assign zptr = {gpr[ZPTR_HI], gpr[ZPTR_LO]};
   assign br_target = pc_o + 16'h0001 + {{9{ofs[6]}}, ofs};
   assign skip_pc = pc_o + (next_long_i ? 16'h0003 : 16'h0002);
   assign acc_pc = ((opc == OP_IND_JUMP) || (opc == OP_IND_CALL)) ? zptr :
                   (is_skip && skip_now) ? skip_pc :
                   br_taken ? br_target : pc_o + 16'h0001;

   // Cycles beyond the first that the taken instruction occupies
   function automatic logic [1:0] camb_extra(input logic [4:0] op, input logic mult,
                                             input logic sk, input logic lg, input logic tk);
      logic [1:0] e;
      e = 2'd0;
      if (op == OP_IND_CALL) begin
         e = 2'd3;
      end else if (mult || op == OP_IND_JUMP || tk) begin
         e = 2'd1;
      end else if (sk) begin
         e = lg ? 2'd2 : 2'd1;
      end
      return e;
   endfunction

   assign extra = camb_extra(opc, is_mult, is_skip && skip_now, next_long_i, br_taken);
   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      unique case (state)
         ST_RUN: begin
            if (acc && extra != 2'd0) begin
               next_state = is_mult ? ST_MULT : ST_HOLD;
               next_cnt = extra - 2'd1;
            end
         end
         ST_MULT: next_state = ST_RUN;
         ST_HOLD: begin
            if (cnt == 2'd0) begin
               next_state = ST_RUN;
            end else begin
               next_cnt = cnt - 2'd1;
            end
         end
      endcase
   end
   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic bus_req;
   logic bus_wr;
   logic hit_gpr;
   logic next_run;
   logic [31:0] rdata;
   assign bus_req = cyc_i && stb_i;
   // Write lands at the edge where ack is seen high
   assign bus_wr = bus_req && we_i && ack_o;
   assign hit_gpr = (adr_i[7] == 1'b0);
   assign next_run = (bus_wr && adr_i == REG_CTRL && sel_i[0]) ? dat_i[0] : run;
   assign rdata = hit_gpr ? {24'h000000, gpr[adr_i[6:2]]} :
                  (adr_i == REG_STATUS) ? {24'h000000, status_o} :
                  (adr_i == REG_PC) ? {16'h0000, pc_o} :
                  (adr_i == REG_SP) ? {{(32-SPW){1'b0}}, sp} :
                  (adr_i == REG_CTRL) ? {31'h0, run} : 32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= bus_req && !ack_o;
         if (bus_req && !ack_o) begin
            dat_o <= rdata;
         end
      end
   end
   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_RUN;
         cnt <= 2'd0;
         run <= RUN_RST;
         ready_o <= RUN_RST;
         pc_o <= PC_RST;
         sp <= '0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         run <= next_run;
         ready_o <= (next_state == ST_RUN) && next_run;
         if (acc) begin
            pc_o <= acc_pc;
         end else if (bus_wr && !run && adr_i == REG_PC) begin
            pc_o <= {sel_i[1] ? dat_i[15:8] : pc_o[15:8], sel_i[0] ? dat_i[7:0] : pc_o[7:0]};
         end
         if (acc && opc == OP_IND_CALL) begin
            sp <= sp + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_o <= STATUS_RST;
      end else if (state == ST_MULT) begin
         status_o[FLG_Z] <= mult_z;
         status_o[FLG_C] <= mult_c;
      end else if (acc && is_logic) begin
         status_o[FLG_Z] <= alu_z;
         status_o[FLG_N] <= alu_n;
         status_o[FLG_V] <= 1'b0;
      end else if (acc && is_cmp) begin
         status_o[FLG_Z] <= alu_z;
         status_o[FLG_N] <= alu_n;
         status_o[FLG_V] <= alu_v;
         status_o[FLG_C] <= alu_c;
         status_o[FLG_H] <= alu_h;
      end else if (bus_wr && !run && adr_i == REG_STATUS && sel_i[0]) begin
         status_o <= dat_i[7:0];
      end
   end
   // ----------------------------------------------------------------
   // Register file and return stack
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (state == ST_MULT) begin
         gpr[0] <= mult_prod[7:0];
         gpr[1] <= mult_prod[15:8];
      end else if (acc && opc == OP_CLR_BITS) begin
         gpr[rd] <= alu_res;
      end else if (bus_wr && !run && hit_gpr && sel_i[0]) begin
         gpr[adr_i[6:2]] <= dat_i[7:0];
      end
      if (acc && opc == OP_IND_CALL) begin
         stack[sp] <= pc_o + 16'h0001;
      end
   end
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_busy_then_ready;
      !ready_o ##1 ready_o;
   endsequence
   property p_clr_bits;
      acc && opc == OP_CLR_BITS |=> ready_o && gpr[$past(rd)] == ($past(vd) & ~$past(kimm))
         && status_o[FLG_Z] == (gpr[$past(rd)] == 8'h00);
   endproperty
   a_clr_bits: assert property (p_clr_bits) else $error("clear bits wrong");
   property p_reg_test;
      acc && opc == OP_REG_TEST |=> ready_o && gpr[$past(rd)] == $past(vd)
         && status_o[FLG_N] == $past(vd[7]) && !status_o[FLG_V];
   endproperty
   a_reg_test: assert property (p_reg_test) else $error("register test wrong");
   property p_mult_time;
      acc && is_mult |=> s_busy_then_ready;
   endproperty
   a_mult_time: assert property (p_mult_time) else $error("multiply not two cycles");
   property p_mult_flags;
      state == ST_MULT |=> status_o[FLG_Z] == ({gpr[1], gpr[0]} == 16'h0000);
   endproperty
   a_mult_flags: assert property (p_mult_flags) else $error("multiply zero flag");
   property p_ind_jump;
      acc && opc == OP_IND_JUMP |=> pc_o == $past(zptr) && status_o == $past(status_o)
         ##0 s_busy_then_ready;
   endproperty
   a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong");
   property p_ind_call;
      acc && opc == OP_IND_CALL |=> pc_o == $past(zptr) ##0 !ready_o [*3] ##1 ready_o;
   endproperty
   a_ind_call: assert property (p_ind_call) else $error("indirect call wrong");
   property p_call_push;
      acc && opc == OP_IND_CALL |=> sp == $past(sp) + 1'b1
         && stack[$past(sp)] == $past(pc_o) + 16'h0001;
   endproperty
   a_call_push: assert property (p_call_push) else $error("call push wrong");
   property p_skip_eq;
      acc && opc == OP_SKIP_EQ && vd == vr && !next_long_i |=>
         pc_o == $past(pc_o) + 16'h0002 ##0 s_busy_then_ready;
   endproperty
   a_skip_eq: assert property (p_skip_eq) else $error("equal skip wrong");
   property p_skip_long;
      acc && is_skip && skip_now && next_long_i |=> !ready_o [*2] ##1 ready_o;
   endproperty
   a_skip_long: assert property (p_skip_long) else $error("long skip timing");
   property p_cmp;
      acc && opc == OP_CMP_REG |=> status_o[FLG_C] == ($past(vd) < $past(vr))
         && status_o[FLG_Z] == ($past(vd) == $past(vr)) && ready_o;
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare flags wrong");
   property p_br_not;
      acc && is_br && !br_taken |=> ready_o && pc_o == $past(pc_o) + 16'h0001;
   endproperty
   a_br_not: assert property (p_br_not) else $error("untaken branch wrong");
   property p_br_zero;
      acc && opc == OP_BR_ZSET && status_o[FLG_Z] |=> pc_o == $past(br_target)
         ##0 s_busy_then_ready;
   endproperty
   a_br_zero: assert property (p_br_zero) else $error("zero branch wrong");
endmodule // camb_core

// ### tb/camb_prog_model.sv
// Program memory model that feeds the core's instruction port
`timescale 1ns/1ps
module camb_prog_model (
   input wire logic clk_i, // Clock
   input wire logic rst_i, // Synchronous reset, high
   input wire logic go_i, // Offer the word at the current pc
   input wire logic ready_i, // Core takes the word at this edge
   input wire logic [15:0] pc_i, // Fetch address
   output logic valid_o, // Word offered
   output logic [23:0] instr_o, // Instruction word
   output logic long_o, // Following instruction is two words
   output logic [7:0] io_o // I/O register named by the word
);
   logic [24:0] mem [0:65535];
   logic [7:0] io_space [0:31];
   logic [23:0] word;
   initial begin
      foreach (mem[a]) mem[a] = 25'h0;
      foreach (io_space[a]) io_space[a] = 8'h00;
   end
   assign word = mem[pc_i][23:0];
   // Lines show the inverse word when nothing is offered
   assign instr_o = valid_o ? word : ~word;
   assign long_o = mem[pc_i + 16'h0001][24];
   assign io_o = io_space[word[18:14]];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
      end else if (go_i) begin
         valid_o <= 1'b1;
      end else if (ready_i) begin
         valid_o <= 1'b0;
      end
   end
endmodule // camb_prog_model

// ### tb/tb_top.sv
// Self-checking bench for the execution core
`timescale 1ns/1ps
module tb_top import camb_pkg::*;;
   localparam logic [15:0] PC0 = 16'h0040;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, rdat, q;
   logic ack, rdy, iv, lng;
   logic [23:0] iw;
   logic [7:0] iob, stat;
   logic [15:0] pc;
   int failures = 0, n_tests = 0, ncyc = 0;
   always #2 clk_i = ~clk_i;
   camb_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .dat_i(wdat), .sel_i(4'hf), .dat_o(rdat), .ack_o(ack), .instr_valid_i(iv),
      .instr_i(iw), .next_long_i(lng), .io_byte_i(iob), .ready_o(rdy), .pc_o(pc),
      .status_o(stat));
   camb_prog_model prog_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .ready_i(rdy), .pc_i(pc),
      .valid_o(iv), .instr_o(iw), .long_o(lng), .io_o(iob));
   // Cycles spent by the last taken instruction
   always @(posedge clk_i) begin
      if (iv && rdy) begin
         ncyc <= 1;
      end else if (!rdy && ncyc != 0) begin
         ncyc <= ncyc + 1;
      end
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic hang();
      failures++;
      $display("CHECK FAILED %0t wait ran out", $time);
      final_report();
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 20);
      if (i >= 20) hang();
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   function automatic logic [23:0] ins(input logic [4:0] op, input logic [4:0] d,
      input logic [4:0] r, input logic [7:0] k);
      return {op, d, r, 1'b0, k};
   endfunction
   // Run one word from PC0 with given flags, then judge pc, flags and cycles
   task automatic ex(input logic [23:0] w, input logic [7:0] s, input logic l,
      input logic [15:0] d, input logic [7:0] es, input int ec);
      int i;
      i = 0;
      wb(1'b1, REG_CTRL, 32'h0);
      wb(1'b1, REG_PC, {16'h0, PC0});
      wb(1'b1, REG_STATUS, {24'h0, s});
      prog_u.mem[PC0] = {1'b0, w};
      prog_u.mem[PC0 + 16'h0001] = {l, 24'h0};
      wb(1'b1, REG_CTRL, 32'h1);
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      do begin
         @(posedge clk_i);
         i++;
      end while ((iv !== 1'b0 || rdy !== 1'b1) && i < 30);
      if (i >= 30) hang();
      chk(pc, 16'(PC0 + d), "pc");
      chk(stat, es, "flags");
      chk(ncyc, ec, "cycles");
   endtask
   task automatic br(input logic [4:0] op, input logic [7:0] k, input logic [7:0] s,
      input logic [15:0] d, input int c);
      ex(ins(op, 5'd0, 5'd0, k), s, 1'b0, d, s, c);
   endtask
   task automatic sk(input logic [4:0] op, input logic [4:0] rd, input logic [4:0] rr,
      input logic [7:0] k, input logic l, input logic [15:0] d, input int c);
      ex(ins(op, rd, rr, k), 8'h2b, l, d, 8'h2b, c);
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk(pc, PC_RST, "pc reset");
      chk(stat, STATUS_RST, "flags reset");
      chk(rdy, RUN_RST, "ready reset");
      wb(1'b0, 8'hf0, 32'h0);
      chk(q, 32'h0, "unmapped read");
      wb(1'b1, REG_PC, 32'h0055);
      wb(1'b0, REG_PC, 32'h0);
      chk(q, 32'h0, "pc written while running");
      wb(1'b1, REG_CTRL, 32'h0);
      wb(1'b1, 8'h40, 32'ha5);
      wb(1'b1, 8'h44, 32'ha5);
      wb(1'b1, 8'h48, 32'h3c);
      wb(1'b1, 8'h4c, 32'hb5);
      wb(1'b1, 8'h50, 32'h00);
      wb(1'b1, 8'h78, 32'h34);
      wb(1'b1, 8'h7c, 32'h12);
      prog_u.io_space[3] = 8'h80;
   endtask
   task automatic t_logic();
      ex(ins(OP_CLR_BITS, 5'd19, 5'd0, 8'h0f), 8'h08, 1'b0, 16'h1, 8'h04, 1);
      wb(1'b0, 8'h4c, 32'h0);
      chk(q, 32'hb0, "cleared bits");
      ex(ins(OP_REG_TEST, 5'd20, 5'd20, 8'h00), 8'h04, 1'b0, 16'h1, 8'h02, 1);
      ex(ins(OP_REG_TEST, 5'd16, 5'd16, 8'h00), 8'h02, 1'b0, 16'h1, 8'h04, 1);
      wb(1'b0, 8'h40, 32'h0);
      chk(q, 32'ha5, "tested register");
   endtask
   task automatic t_mult();
      logic [4:0] op;
      logic [15:0] p;
      logic sa, sb;
      int x;
      for (int k = 0; k < 6; k++) begin
         op = OP_MPY_U + 5'(k);
         sa = op != OP_MPY_U && op != OP_FMPY_U;
         sb = op == OP_MPY_S || op == OP_FMPY_S;
         x = (sa ? int'($signed(8'ha5)) : 165) * (sb ? int'($signed(8'h3c)) : 60);
         p = (op >= OP_FMPY_U) ? {x[14:0], 1'b0} : x[15:0];
         ex(ins(op, 5'd16, 5'd18, 8'h00), 8'h2c, 1'b0, 16'h1,
            {6'b001011, p == 16'h0, x[15]}, 2);
         wb(1'b0, 8'h00, 32'h0);
         chk(q, {24'h0, p[7:0]}, "product low");
         wb(1'b0, 8'h04, 32'h0);
         chk(q, {24'h0, p[15:8]}, "product high");
      end
   endtask
   task automatic t_jump();
      ex(ins(OP_IND_JUMP, 5'd0, 5'd0, 8'h00), 8'h2b, 1'b0, 16'h1234 - PC0, 8'h2b, 2);
      ex(ins(OP_IND_CALL, 5'd0, 5'd0, 8'h00), 8'h2b, 1'b0, 16'h1234 - PC0, 8'h2b, 4);
      wb(1'b0, REG_SP, 32'h0);
      chk(q, 32'h1, "stack depth after call");
   endtask
   task automatic t_compare();
      ex(ins(OP_CMP_REG, 5'd16, 5'd18, 8'h00), 8'h00, 1'b0, 16'h1, 8'h28, 1);
      ex(ins(OP_CMP_CARRY, 5'd16, 5'd17, 8'h00), 8'h03, 1'b0, 16'h1, 8'h25, 1);
      ex(ins(OP_CMP_CARRY, 5'd16, 5'd17, 8'h00), 8'h00, 1'b0, 16'h1, 8'h00, 1);
      ex(ins(OP_CMP_IMM, 5'd18, 5'd0, 8'h3c), 8'h00, 1'b0, 16'h1, 8'h02, 1);
      wb(1'b0, 8'h40, 32'h0);
      chk(q, 32'ha5, "compared register");
   endtask
   task automatic t_skip();
      sk(OP_SKIP_EQ, 5'd16, 5'd17, 8'h00, 1'b0, 16'h2, 2);
      sk(OP_SKIP_EQ, 5'd16, 5'd17, 8'h00, 1'b1, 16'h3, 3);
      sk(OP_SKIP_EQ, 5'd16, 5'd18, 8'h00, 1'b1, 16'h1, 1);
      sk(OP_SKIP_RCLR, 5'd18, 5'd18, 8'h00, 1'b0, 16'h2, 2);
      sk(OP_SKIP_RSET, 5'd18, 5'd18, 8'h00, 1'b0, 16'h1, 1);
      sk(OP_SKIP_RSET, 5'd18, 5'd18, 8'h02, 1'b1, 16'h3, 3);
      sk(OP_SKIP_IOCLR, 5'd3, 5'd0, 8'h07, 1'b0, 16'h1, 1);
      sk(OP_SKIP_IOSET, 5'd3, 5'd0, 8'h07, 1'b1, 16'h3, 3);
      sk(OP_SKIP_IOCLR, 5'd3, 5'd0, 8'h00, 1'b0, 16'h2, 2);
   endtask
   task automatic t_branch();
      br(OP_BR_FSET, 8'h0a, 8'h04, 16'h000b, 2);
      br(OP_BR_FSET, 8'h0a, 8'h00, 16'h0001, 1);
      br(OP_BR_FCLR, 8'h7d, 8'h00, 16'hfffe, 2);
      br(OP_BR_FCLR, 8'h7d, 8'h20, 16'h0001, 1);
      br(OP_BR_ZSET, 8'h05, 8'h02, 16'h0006, 2);
      br(OP_BR_ZCLR, 8'h05, 8'h02, 16'h0001, 1);
      br(OP_BR_CSET, 8'h05, 8'h00, 16'h0001, 1);
      br(OP_BR_CCLR, 8'h7d, 8'h00, 16'hfffe, 2);
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_logic();
      t_mult();
      t_jump();
      t_compare();
      t_skip();
      t_branch();
      final_report();
   end
endmodule // tb_top
